// [core/drive_ctl_regs.vh]
/*
 * Register offsets, field positions, reset values, mode codes and timing counts
 * for the drive control and status register bank.
 * Assumes it is included by bare name from the core/ design files.
 */
`ifndef DRIVE_CTL_REGS_VH
`define DRIVE_CTL_REGS_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define ADDR_DRIVE_STATUS_B 16'h03f1
`define ADDR_DRIVE_OUTPUT_CONTROL 16'h03f2
`define ADDR_TAPE_DRIVE_ASSIGN 16'h03f3
`define ADDR_DIGITAL_INPUT 16'h03f7

// ----------------------------------------------------------------------------
// Output control fields and reset values
// ----------------------------------------------------------------------------
`define DOC_SEL_LSB 0
`define DOC_SEL_MSB 1
`define DOC_RESET_N_BIT 2
`define DOC_DMA_BIT 3
`define DOC_MOTOR_LSB 4
`define DOC_MOTOR_MSB 7
`define DOC_RESET_VALUE 8'h00
`define TAPE_RESET_VALUE 2'h0
`define TAPE_READ_OE 8'h03
`define STATUS_B_RESERVED 2'h3

// ----------------------------------------------------------------------------
// Personality modes
// ----------------------------------------------------------------------------
`define MODE_LEGACY 2'h0
`define MODE_FIRST 2'h1
`define MODE_SECOND 2'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_MHZ 200
`define SOFT_RESET_MIN_NS 100
`define SOFT_RESET_CYCLES ((`SOFT_RESET_MIN_NS * `CLK_MHZ + 999) / 1000)

`endif

// [core/pin_sync.v]
/*
 * Three-stage synchroniser for one asynchronous pin with rise and fall pulses.
 * Assumes the pin may change at any time relative to the clock.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter RESET_LEVEL = 1'b1
) (
    input wire clk_i,
    input wire nrst_i,
    input wire pin_i,
    output reg level_o,
    output wire rise_o,
    output wire fall_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg prev_q;

    // A change counts only once the second and third stages agree.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= RESET_LEVEL;
            s2_q <= RESET_LEVEL;
            s3_q <= RESET_LEVEL;
            level_o <= RESET_LEVEL;
            prev_q <= RESET_LEVEL;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_o <= s3_q;
            end
            prev_q <= level_o;
        end
    end

    assign rise_o = level_o & ~prev_q;
    assign fall_o = ~level_o & prev_q;
endmodule

// [core/two_drive_decode.v]
/*
 * Internal two-drive decode of select and motor outputs, normal or swapped.
 * Assumes the caller registers the results before they reach pins.
 */
`timescale 1ns/1ps
module two_drive_decode (
    input wire [1:0] sel_i,
    input wire [1:0] mot_i,
    input wire swap_i,
    output reg [1:0] pick_low_o,
    output reg [1:0] motor_low_o
);
    reg hit0;
    reg hit1;

    always @* begin
        hit0 = (sel_i == 2'h0) & mot_i[0];
        hit1 = (sel_i == 2'h1) & mot_i[1];
        if (swap_i) begin
            pick_low_o = {~hit0, ~hit1};
            motor_low_o = {~mot_i[0], ~mot_i[1]};
        end else begin
            pick_low_o = {~hit1, ~hit0};
            motor_low_o = {~mot_i[1], ~mot_i[0]};
        end
    end
endmodule

// [core/drive_ctl_regs.v]
/*
 * Drive control and status register bank: status B, output control, tape assign.
 * Assumes an 8-bit I/O host port with address stable while a strobe is low,
 * strobes held low for more than four clocks, and write gate and write data
 * coming from controller logic on the same clock.
 */
`timescale 1ns/1ps
`include "drive_ctl_regs.vh"
module drive_ctl_regs (
    input wire SYS_CLK_I,
    input wire NRST_I,
    input wire [15:0] ADDR_I,
    input wire IOR_N_I,
    input wire IOW_N_I,
    input wire [7:0] DATA_I,
    output reg [7:0] DATA_O,
    output reg [7:0] DATA_OE_O,
    input wire [1:0] MODE_I,
    input wire SWAP_I,
    input wire WRITE_GATE_I,
    input wire WRITE_DATA_I,
    input wire READ_DATA_N_I,
    input wire SECOND_DRIVE_PRESENT_N_I,
    output reg [3:0] DRIVE_PICK_O,
    output reg [3:0] MOTOR_OUT_O,
    output reg [1:0] DRIVE_PICK_LOW_O,
    output reg [1:0] MOTOR_LOW_O,
    output reg SOFT_RESET_N_O,
    output reg DMA_GATE_O,
    output reg [3:0] TAPE_PICK_O
);
    // The count is worked out as an integer and narrowed on purpose; it must stay below 32.
    localparam integer RESET_HOLD_INT = `SOFT_RESET_CYCLES;
    localparam [4:0] RESET_HOLD = RESET_HOLD_INT[4:0];

    wire ior_lvl;
    wire ior_fall;
    wire iow_fall;
    wire rdata_rise;
    wire drv2_lvl;
    wire [1:0] pick_low_d;
    wire [1:0] motor_low_d;
    reg [7:0] doc_q;
    reg [1:0] tape_q;
    reg write_gate_q;
    reg write_data_q;
    reg rd_toggle_q;
    reg wd_toggle_q;
    reg gate_latch_q;
    reg rd_latch_q;
    reg wd_latch_q;
    reg [4:0] hold_q;
    reg [3:0] pick_d;
    reg [7:0] rdata_d;
    reg [7:0] roe_d;
    reg dir_read;
    reg [7:0] status_first;
    reg [7:0] status_second;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    pin_sync #(.RESET_LEVEL(1'b1)) u_ior (
        .clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .pin_i(IOR_N_I),
        .level_o(ior_lvl),
        .rise_o(),
        .fall_o(ior_fall)
    );

    pin_sync #(.RESET_LEVEL(1'b1)) u_iow (
        .clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .pin_i(IOW_N_I),
        .level_o(),
        .rise_o(),
        .fall_o(iow_fall)
    );

    // The read data pin is active low, so its inactive edge is a rise.
    pin_sync #(.RESET_LEVEL(1'b1)) u_rdata (
        .clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .pin_i(READ_DATA_N_I),
        .level_o(),
        .rise_o(rdata_rise),
        .fall_o()
    );

    pin_sync #(.RESET_LEVEL(1'b1)) u_drv2 (
        .clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .pin_i(SECOND_DRIVE_PRESENT_N_I),
        .level_o(drv2_lvl),
        .rise_o(),
        .fall_o()
    );

    // ------------------------------------------------------------------------
    // Drive decode
    // ------------------------------------------------------------------------
    // Selects are gated by the matching motor bit so that status reads one at reset.
    always @* begin
        pick_d = 4'h0;
        pick_d[doc_q[`DOC_SEL_MSB:`DOC_SEL_LSB]] = doc_q[`DOC_MOTOR_LSB + doc_q[`DOC_SEL_MSB:`DOC_SEL_LSB]];
    end

    two_drive_decode u_decode (
        .sel_i(doc_q[`DOC_SEL_MSB:`DOC_SEL_LSB]),
        .mot_i(doc_q[`DOC_MOTOR_LSB + 1:`DOC_MOTOR_LSB]),
        .swap_i(SWAP_I),
        .pick_low_o(pick_low_d),
        .motor_low_o(motor_low_d)
    );

    // ------------------------------------------------------------------------
    // Host writes
    // ------------------------------------------------------------------------
    // Only the hardware reset touches these; the soft reset leaves them alone.
    // Writes to status B and the digital input address fall through, as both are read-only.
    always @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            doc_q <= `DOC_RESET_VALUE;
            tape_q <= `TAPE_RESET_VALUE;
        end else if (iow_fall) begin
            if (ADDR_I == `ADDR_DRIVE_OUTPUT_CONTROL) begin
                doc_q <= DATA_I;
            end
            if (ADDR_I == `ADDR_TAPE_DRIVE_ASSIGN) begin
                tape_q <= DATA_I[1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Soft reset stretch
    // ------------------------------------------------------------------------
    // Stretching lets back-to-back writes still give the controller a full reset.
    // Setting bit 2 again at once does not cut the stretch short, so the full count always runs.
    always @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            hold_q <= 5'h00;
            SOFT_RESET_N_O <= 1'b0;
        end else begin
            if (!doc_q[`DOC_RESET_N_BIT]) begin
                hold_q <= RESET_HOLD;
            end else if (hold_q != 5'h00) begin
                hold_q <= hold_q - 5'h01;
            end
            SOFT_RESET_N_O <= doc_q[`DOC_RESET_N_BIT] & (hold_q == 5'h00);
        end
    end

    // ------------------------------------------------------------------------
    // Status tracking
    // ------------------------------------------------------------------------
    // Only the strobe of a digital input read is used here; that register's data lives elsewhere.
    always @* begin
        dir_read = ior_fall & (ADDR_I == `ADDR_DIGITAL_INPUT);
    end

    always @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            write_gate_q <= 1'b0;
            write_data_q <= 1'b0;
            rd_toggle_q <= 1'b0;
            wd_toggle_q <= 1'b0;
            gate_latch_q <= 1'b0;
            rd_latch_q <= 1'b0;
            wd_latch_q <= 1'b0;
        end else begin
            write_gate_q <= WRITE_GATE_I;
            write_data_q <= WRITE_DATA_I;
            if (rdata_rise) begin
                rd_toggle_q <= ~rd_toggle_q;
            end
            if (write_data_q & ~WRITE_DATA_I) begin
                wd_toggle_q <= ~wd_toggle_q;
            end
            // An edge in the cycle of the clearing read still sets the latch.
            if (WRITE_GATE_I & ~write_gate_q) begin
                gate_latch_q <= 1'b1;
            end else if (dir_read) begin
                gate_latch_q <= 1'b0;
            end
            if (rdata_rise) begin
                rd_latch_q <= 1'b1;
            end else if (dir_read) begin
                rd_latch_q <= 1'b0;
            end
            if (write_data_q & ~WRITE_DATA_I) begin
                wd_latch_q <= 1'b1;
            end else if (dir_read) begin
                wd_latch_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Drive side outputs
    // ------------------------------------------------------------------------
    always @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            DRIVE_PICK_O <= 4'h0;
            MOTOR_OUT_O <= 4'h0;
            DRIVE_PICK_LOW_O <= 2'h3;
            MOTOR_LOW_O <= 2'h3;
            DMA_GATE_O <= 1'b0;
            TAPE_PICK_O <= 4'h0;
        end else begin
            DRIVE_PICK_O <= pick_d;
            MOTOR_OUT_O <= doc_q[`DOC_MOTOR_MSB:`DOC_MOTOR_LSB];
            DRIVE_PICK_LOW_O <= pick_low_d;
            MOTOR_LOW_O <= motor_low_d;
            // Mode code 3 is treated like legacy, so the gate follows the register bit.
            if (MODE_I == `MODE_FIRST) begin
                DMA_GATE_O <= 1'b1;
            end else begin
                DMA_GATE_O <= doc_q[`DOC_DMA_BIT];
            end
            TAPE_PICK_O <= {(tape_q == 2'h3), (tape_q == 2'h2), (tape_q == 2'h1), 1'b0};
        end
    end

    // ------------------------------------------------------------------------
    // Status B words
    // ------------------------------------------------------------------------
    // Both words come from registered state, so a read never sees a pin in mid-change.
    always @* begin
        status_first = {`STATUS_B_RESERVED, doc_q[`DOC_SEL_LSB], wd_toggle_q, rd_toggle_q,
                        write_gate_q, MOTOR_OUT_O[1], MOTOR_OUT_O[0]};
        status_second = {drv2_lvl, ~DRIVE_PICK_O[1], ~DRIVE_PICK_O[0], wd_latch_q, rd_latch_q,
                         gate_latch_q, ~DRIVE_PICK_O[3], ~DRIVE_PICK_O[2]};
    end

    // ------------------------------------------------------------------------
    // Host reads
    // ------------------------------------------------------------------------
    always @* begin
        rdata_d = 8'h00;
        roe_d = 8'h00;
        case (ADDR_I)
            `ADDR_DRIVE_STATUS_B: begin
                if (MODE_I == `MODE_FIRST) begin
                    roe_d = 8'hff;
                    rdata_d = status_first;
                end else if (MODE_I == `MODE_SECOND) begin
                    roe_d = 8'hff;
                    rdata_d = status_second;
                end else begin
                    roe_d = 8'h00;
                end
            end
            `ADDR_DRIVE_OUTPUT_CONTROL: begin
                roe_d = 8'hff;
                rdata_d = doc_q;
            end
            `ADDR_TAPE_DRIVE_ASSIGN: begin
                roe_d = `TAPE_READ_OE;
                rdata_d = {6'h00, tape_q};
            end
            default: begin
                roe_d = 8'h00;
            end
        endcase
    end

    // The bus is driven only while the synchronised read strobe is low.
    // Tape bits 7:2 and unmapped addresses keep their enables low, so those lines float.
    always @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            DATA_O <= 8'h00;
            DATA_OE_O <= 8'h00;
        end else begin
            DATA_O <= rdata_d;
            DATA_OE_O <= ior_lvl ? 8'h00 : roe_d;
        end
    end
endmodule

// [tb/drive_ctl_regs_props.sv]
/* Port assertions for the drive control register bank.
   Assumes the header sits on the include path and MODE_I changes only in reset. */
`timescale 1ns/1ps
`include "drive_ctl_regs.vh"
module drive_ctl_regs_props (
    input wire SYS_CLK_I,
    input wire NRST_I,
    input wire [15:0] ADDR_I,
    input wire [1:0] MODE_I,
    input wire SWAP_I,
    input wire [7:0] DATA_O,
    input wire [7:0] DATA_OE_O,
    input wire [3:0] DRIVE_PICK_O,
    input wire [3:0] MOTOR_OUT_O,
    input wire [1:0] DRIVE_PICK_LOW_O,
    input wire [1:0] MOTOR_LOW_O,
    input wire DMA_GATE_O,
    input wire [3:0] TAPE_PICK_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);
    // Eight steady cycles on the address let any earlier read's enables drain.
    sequence first_srb_s;
        (MODE_I == `MODE_FIRST && ADDR_I == `ADDR_DRIVE_STATUS_B)[*8] ##0 (DATA_OE_O != 8'h00);
    endsequence
    sequence legacy_srb_s;
        (MODE_I == `MODE_LEGACY && ADDR_I == `ADDR_DRIVE_STATUS_B)[*8];
    endsequence
    one_pick_a:
        assert property ($onehot0(DRIVE_PICK_O)) else $error("more than one drive picked");
    pick_motor_a:
        assert property ((DRIVE_PICK_O & ~MOTOR_OUT_O) == 4'h0) else $error("pick without motor");
    tape_pick_a:
        assert property ($onehot0(TAPE_PICK_O) && !TAPE_PICK_O[0]) else $error("bad tape pick");
    legacy_float_a:
        assert property (legacy_srb_s |-> DATA_OE_O == 8'h00) else $error("legacy status driven");
    reserved_ones_a:
        assert property (first_srb_s |-> DATA_O[7:6] == 2'h3) else $error("reserved bits not one");
    motor_status_a:
        assert property (first_srb_s |-> DATA_O[1:0] == MOTOR_OUT_O[1:0]) else $error("motor status wrong");
    first_dma_a:
        assert property (MODE_I == `MODE_FIRST && NRST_I |=> DMA_GATE_O) else $error("dma gate off in first mode");
    normal_decode_a:
        assert property (!SWAP_I |-> DRIVE_PICK_LOW_O == ~DRIVE_PICK_O[1:0] && MOTOR_LOW_O == ~MOTOR_OUT_O[1:0])
            else $error("normal decode wrong");
    swap_decode_a:
        assert property (SWAP_I |-> DRIVE_PICK_LOW_O == ~{DRIVE_PICK_O[0], DRIVE_PICK_O[1]}
            && MOTOR_LOW_O == ~{MOTOR_OUT_O[0], MOTOR_OUT_O[1]}) else $error("swapped decode wrong");
endmodule
bind drive_ctl_regs drive_ctl_regs_props u_props (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I),
    .MODE_I(MODE_I), .SWAP_I(SWAP_I), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O), .DRIVE_PICK_O(DRIVE_PICK_O),
    .MOTOR_OUT_O(MOTOR_OUT_O), .DRIVE_PICK_LOW_O(DRIVE_PICK_LOW_O), .MOTOR_LOW_O(MOTOR_LOW_O),
    .DMA_GATE_O(DMA_GATE_O), .TAPE_PICK_O(TAPE_PICK_O));

// [tb/floppy_drive_model.sv]
/* Behavioural floppy drive on the far side of the drive pins.
   Assumes active-high selects and motor enables from the register bank. */
`timescale 1ns/1ps
module floppy_drive_model #(
    parameter PRESENT_N = 1'b0
) (
    input wire clk_i,
    input wire [3:0] pick_i,
    input wire [3:0] motor_i,
    output reg read_data_n_o,
    output wire present_n_o
);
    // A drive sends read data only while picked and spinning; otherwise the model holds the line high itself.
    assign present_n_o = PRESENT_N;
    initial read_data_n_o = 1'b1;
    task emit;
    begin
        @(posedge clk_i);
        if (|(pick_i & motor_i)) begin
            read_data_n_o <= 1'b0;
            repeat (6) @(posedge clk_i);
            read_data_n_o <= 1'b1;
        end
        repeat (8) @(posedge clk_i);
    end
    endtask
endmodule

// [tb/drive_ctl_regs_tb_top.sv]
/* Self-checking bench for the drive control register bank.
   Assumes the design and its header are compiled alongside. */
`timescale 1ns/1ps
`include "drive_ctl_regs.vh"
module drive_ctl_regs_tb_top;
    reg clk = 1'b0;
    reg nrst_n = 1'b0;
    reg [15:0] addr = 16'h0000;
    reg ior_n = 1'b1;
    reg iow_n = 1'b1;
    reg [7:0] wdat = 8'h00;
    reg [1:0] mode = 2'h0;
    reg swap = 1'b0;
    reg write_gate = 1'b0;
    reg wdata = 1'b0;
    wire rdata_n, drv2_n, srst_n, dma;
    wire [7:0] dout, doe;
    wire [3:0] pick, motor, tape;
    wire [1:0] pick_low, motor_low;
    reg [7:0] rd, oe;
    reg [1:0] e2;
    integer n_fail = 0;
    integer checks = 0;
    integer i;
    always #2.5 clk = ~clk;
    drive_ctl_regs u_dut (.SYS_CLK_I(clk), .NRST_I(nrst_n), .ADDR_I(addr), .IOR_N_I(ior_n), .IOW_N_I(iow_n),
        .DATA_I(wdat), .DATA_O(dout), .DATA_OE_O(doe), .MODE_I(mode), .SWAP_I(swap), .WRITE_GATE_I(write_gate),
        .WRITE_DATA_I(wdata), .READ_DATA_N_I(rdata_n), .SECOND_DRIVE_PRESENT_N_I(drv2_n), .DRIVE_PICK_O(pick),
        .MOTOR_OUT_O(motor), .DRIVE_PICK_LOW_O(pick_low), .MOTOR_LOW_O(motor_low), .SOFT_RESET_N_O(srst_n),
        .DMA_GATE_O(dma), .TAPE_PICK_O(tape));
    floppy_drive_model #(.PRESENT_N(1'b0)) u_drv (.clk_i(clk), .pick_i(pick), .motor_i(motor),
        .read_data_n_o(rdata_n), .present_n_o(drv2_n));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task chk(input [7:0] got, input [7:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task give_verdict;
    begin
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    // Strobes stay low and high eight clocks, above the five the synchronisers need.
    task wr(input [15:0] a, input [7:0] d);
    begin
        @(posedge clk);
        addr <= a;
        wdat <= d;
        iow_n <= 1'b0;
        repeat (8) @(posedge clk);
        iow_n <= 1'b1;
        repeat (8) @(posedge clk);
    end
    endtask
    task rdr(input [15:0] a);
    begin
        @(posedge clk);
        addr <= a;
        ior_n <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        rd = dout;
        oe = doe;
        @(posedge clk);
        ior_n <= 1'b1;
        repeat (8) @(posedge clk);
    end
    endtask
    task hw_reset(input [1:0] m, input s);
    begin
        @(posedge clk);
        nrst_n <= 1'b0;
        mode <= m;
        swap <= s;
        repeat (5) @(posedge clk);
        nrst_n <= 1'b1;
        repeat (2) @(posedge clk);
    end
    endtask
    task pulse(input g);
    begin
        @(posedge clk);
        if (g) write_gate <= 1'b1; else wdata <= 1'b1;
        repeat (3) @(posedge clk);
        write_gate <= 1'b0;
        wdata <= 1'b0;
        repeat (3) @(posedge clk);
    end
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        hw_reset(`MODE_LEGACY, 1'b0);
        chk({4'h0, pick_low, motor_low}, 8'h0f);
        chk({7'h0, srst_n}, 8'h00);
        rdr(`ADDR_DRIVE_OUTPUT_CONTROL);
        chk(rd, `DOC_RESET_VALUE);
        rdr(`ADDR_DRIVE_STATUS_B);
        chk(oe, 8'h00);
        rdr(16'h03f0);
        chk(oe, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ADDR_DRIVE_OUTPUT_CONTROL, (8'h10 << i) | 8'h0c | i[7:0]);
            repeat (25) @(posedge clk);
            e2 = (i < 2) ? (2'b01 << i) : 2'b00;
            chk({pick, motor}, {4'h1 << i, 4'h1 << i});
            chk({2'h0, srst_n, dma, pick_low, motor_low}, {4'h3, ~e2, ~e2});
            rdr(`ADDR_DRIVE_OUTPUT_CONTROL);
            chk(rd, (8'h10 << i) | 8'h0c | i[7:0]);
        end
        wr(`ADDR_DRIVE_OUTPUT_CONTROL, 8'h01);
        chk({pick, pick_low}, 8'h03);
        wr(`ADDR_DRIVE_OUTPUT_CONTROL, 8'h88);
        wr(`ADDR_TAPE_DRIVE_ASSIGN, 8'hff);
        chk({2'h0, srst_n, dma, motor}, 8'h18);
        wr(`ADDR_DRIVE_OUTPUT_CONTROL, 8'h84);
        chk({7'h0, srst_n}, 8'h00);
        repeat (25) @(posedge clk);
        chk({2'h0, srst_n, dma, motor}, 8'h28);
        rdr(`ADDR_TAPE_DRIVE_ASSIGN);
        chk(oe & rd, 8'h03);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ADDR_TAPE_DRIVE_ASSIGN, i[7:0]);
            chk({4'h0, tape}, (i == 0) ? 8'h00 : (8'h01 << i));
            rdr(`ADDR_TAPE_DRIVE_ASSIGN);
            chk(oe, 8'h03);
            chk(rd & 8'h03, i[7:0]);
        end
        hw_reset(`MODE_FIRST, 1'b0);
        chk({7'h0, dma}, 8'h01);
        wr(`ADDR_DRIVE_OUTPUT_CONTROL, 8'h2d);
        @(posedge clk);
        write_gate <= 1'b1;
        rdr(`ADDR_DRIVE_STATUS_B);
        chk(rd, 8'he6);
        @(posedge clk);
        write_gate <= 1'b0;
        pulse(1'b0);
        u_drv.emit;
        rdr(`ADDR_DRIVE_STATUS_B);
        chk(rd, 8'hfa);
        pulse(1'b0);
        u_drv.emit;
        rdr(`ADDR_DRIVE_STATUS_B);
        chk(rd, 8'he2);
        hw_reset(`MODE_SECOND, 1'b0);
        rdr(`ADDR_DRIVE_STATUS_B);
        chk(rd, 8'h63);
        wr(`ADDR_DRIVE_OUTPUT_CONTROL, 8'h1c);
        pulse(1'b0);
        u_drv.emit;
        pulse(1'b1);
        rdr(`ADDR_DRIVE_STATUS_B);
        chk(rd, 8'h5f);
        chk({7'h0, dma}, 8'h01);
        rdr(`ADDR_DIGITAL_INPUT);
        rdr(`ADDR_DRIVE_STATUS_B);
        chk(rd, 8'h43);
        hw_reset(`MODE_LEGACY, 1'b1);
        wr(`ADDR_DRIVE_OUTPUT_CONTROL, 8'h1c);
        chk({4'h0, pick_low, motor_low}, 8'h05);
        wr(`ADDR_DRIVE_OUTPUT_CONTROL, 8'h2d);
        chk({4'h0, pick_low, motor_low}, 8'h0a);
        give_verdict;
    end
    // The whole sequence needs about 850 clocks; the limit leaves ample room.
    initial begin
        #100000;
        n_fail = n_fail + 1;
        give_verdict;
    end
endmodule
